// ### core/ssa_params.svh
`ifndef SSA_PARAMS_SVH
`define SSA_PARAMS_SVH

// ***************************************************************
// register byte offsets
// ***************************************************************
`define SSA_OFS_INSTR      12'h000
`define SSA_OFS_ACC        12'h004
`define SSA_OFS_FLAGS      12'h008
`define SSA_OFS_PC         12'h00c
`define SSA_OFS_PARAM      12'h010
`define SSA_OFS_MEM_BASE   12'h200

// ***************************************************************
// field positions
// ***************************************************************
`define SSA_FLAGS_CARRY    0
`define SSA_FLAGS_ZERO     1
`define SSA_PARAM_WDT_BIT  3

// ***************************************************************
// reset values
// ***************************************************************
`define SSA_RST_NIBBLE     4'h0
`define SSA_RST_FLAG       1'b0
`define SSA_RST_PC         11'h000

// ***************************************************************
// instruction codes and masks
// ***************************************************************
`define SSA_MASK_R         16'hff80
`define SSA_MASK_WI        16'hff00
`define SSA_MASK_PARAM     16'hfff0
`define SSA_MASK_FULL      16'hffff
`define SSA_CODE_SUBB_MEM  16'h1400
`define SSA_CODE_SUBB_IMM  16'h0e00
`define SSA_CODE_SUBBW_MEM 16'h1600
`define SSA_CODE_SUBBW_IMM 16'h0f00
`define SSA_CODE_SET_CARRY 16'h5020
`define SSA_CODE_SET_PARAM 16'h1680
`define SSA_CODE_SHL_CARRY 16'h4c00
`define SSA_CODE_SHR_CARRY 16'h4d00
`define SSA_CODE_SKIP_B0   16'h8800

// ***************************************************************
// timing counts in oscillator cycles
// ***************************************************************
`define SSA_WDT_SLOW_DIV   16384
`define SSA_WDT_FAST_DIV   1024

`endif

// ### core/ssa_pkg.sv
package ssa_pkg;

   typedef enum logic [3:0] {
      ssa_op_none,
      ssa_op_subb_mem,
      ssa_op_subb_imm,
      ssa_op_subbw_mem,
      ssa_op_subbw_imm,
      ssa_op_set_carry,
      ssa_op_set_param,
      ssa_op_shl_carry,
      ssa_op_shr_carry,
      ssa_op_skip_b0
   } ssa_op_type;

   typedef enum logic [2:0] {
      ssa_sel_none,
      ssa_sel_instr,
      ssa_sel_acc,
      ssa_sel_flags,
      ssa_sel_pc,
      ssa_sel_param,
      ssa_sel_mem
   } ssa_sel_type;

endpackage

// ### core/ssa_alu.sv
// Function
// - subtract_with_borrow on a memory operand loads memory nibble minus accumulator minus carry into the accumulator only, in one cycle.
// - subtract_with_borrow on an immediate loads working register minus immediate minus carry into the accumulator only, in one cycle.
// - subtract_borrow_writeback on a memory operand stores memory minus accumulator minus carry in the accumulator and that memory nibble.
// - subtract_borrow_writeback on an immediate stores working register minus immediate minus carry in the accumulator and that register.
// - every borrow subtract updates carry and zero from its result and touches no other flag.
// - set-carry forces carry to one in one cycle, steps the program counter by one and changes nothing else.
// - the parameter-flag write takes a 4-bit immediate whose bit 3 switches the watchdog clock to oscillator over 16384, bits 0 to 2 reserved.
// - shift_left_through_carry moves the nibble up, old bit 3 to carry, zero into bit 0, result to memory and accumulator.
// - shift_right_through_carry moves the nibble down, old bit 0 to carry, zero into bit 3, result to memory and accumulator.
// - skip_if_bit0_set adds two to the program counter when memory bit 0 is one and one otherwise, in one cycle.
// - memory-operand instructions address data memory with the 7-bit field in the low bits of the instruction word.
`timescale 1ns/100ps
`include "ssa_params.svh"

module ssa_alu
   import ssa_pkg::*;
#(
   parameter int unsigned WDT_SLOW_DIV = `SSA_WDT_SLOW_DIV,
   parameter int unsigned WDT_FAST_DIV = `SSA_WDT_FAST_DIV,
   parameter int unsigned MEM_DEPTH    = 128,
   parameter int unsigned PC_W         = 11
)(
   // clock and reset
   input  wire logic              pclk,
   input  wire logic              presetn,
   // apb slave
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [11:0]       paddr,
   input  wire logic [31:0]       pwdata,
   input  wire logic [3:0]        pstrb,
   output logic      [31:0]       prdata,
   output logic                   pready,
   output logic                   pslverr,
   // core state
   output logic      [3:0]        result_nibble_reg,
   output logic                   carry_flag,
   output logic                   zero_flag,
   output logic      [PC_W-1:0]   program_counter,
   // watchdog clock
   output logic                   wdt_clk_slow,
   output logic                   wdt_tick
);

   localparam int unsigned MA_W  = $clog2(MEM_DEPTH);
   localparam int unsigned DIV_W = $clog2(WDT_SLOW_DIV + 1);

   // ***************************************************************
   // decode functions
   // ***************************************************************
   function automatic logic hit(input logic [15:0] word, input logic [15:0] code, input logic [15:0] mask);
      hit = ((word & mask) == code);
   endfunction

   function automatic ssa_op_type decode_op(input logic [15:0] word);
      decode_op = ssa_op_none;
      if (hit(word, `SSA_CODE_SUBB_MEM, `SSA_MASK_R))
         decode_op = ssa_op_subb_mem;
      else if (hit(word, `SSA_CODE_SUBB_IMM, `SSA_MASK_WI))
         decode_op = ssa_op_subb_imm;
      else if (hit(word, `SSA_CODE_SUBBW_MEM, `SSA_MASK_R))
         decode_op = ssa_op_subbw_mem;
      else if (hit(word, `SSA_CODE_SUBBW_IMM, `SSA_MASK_WI))
         decode_op = ssa_op_subbw_imm;
      else if (hit(word, `SSA_CODE_SET_CARRY, `SSA_MASK_FULL))
         decode_op = ssa_op_set_carry;
      else if (hit(word, `SSA_CODE_SET_PARAM, `SSA_MASK_PARAM))
         decode_op = ssa_op_set_param;
      else if (hit(word, `SSA_CODE_SHL_CARRY, `SSA_MASK_R))
         decode_op = ssa_op_shl_carry;
      else if (hit(word, `SSA_CODE_SHR_CARRY, `SSA_MASK_R))
         decode_op = ssa_op_shr_carry;
      else if (hit(word, `SSA_CODE_SKIP_B0, `SSA_MASK_R))
         decode_op = ssa_op_skip_b0;
   endfunction

   function automatic ssa_sel_type decode_sel(input logic [11:0] addr);
      decode_sel = ssa_sel_none;
      if (addr[1:0] != 2'h0)
         decode_sel = ssa_sel_none;
      else if (addr >= `SSA_OFS_MEM_BASE && addr < (`SSA_OFS_MEM_BASE + 12'(MEM_DEPTH * 4)))
         decode_sel = ssa_sel_mem;
      else begin
         case (addr)
            `SSA_OFS_INSTR: decode_sel = ssa_sel_instr;
            `SSA_OFS_ACC:   decode_sel = ssa_sel_acc;
            `SSA_OFS_FLAGS: decode_sel = ssa_sel_flags;
            `SSA_OFS_PC:    decode_sel = ssa_sel_pc;
            `SSA_OFS_PARAM: decode_sel = ssa_sel_param;
            default:        decode_sel = ssa_sel_none;
         endcase
      end
   endfunction

   // ***************************************************************
   // state
   // ***************************************************************
   logic [3:0]        acc_q;
   logic              carry_q;
   logic              zero_q;
   logic [PC_W-1:0]   pc_q;
   logic              wdt_slow_q;
   logic [3:0]        mem_q [MEM_DEPTH];
   logic [31:0]       rdata_q;
   logic [DIV_W-1:0]  div_q;
   logic              tick_q;

   // ***************************************************************
   // apb decode
   // ***************************************************************
   ssa_sel_type       sel;
   logic              acc_phase;
   logic              wr_en;
   logic [MA_W-1:0]   bus_idx;

   assign sel       = decode_sel(paddr);
   assign acc_phase = psel && penable;
   assign wr_en     = acc_phase && pwrite && pstrb[0] && (sel != ssa_sel_none);
   assign bus_idx   = MA_W'((paddr - `SSA_OFS_MEM_BASE) >> 2);
   assign pready    = 1'b1;
   assign pslverr   = acc_phase && (sel == ssa_sel_none);

   // ***************************************************************
   // instruction execute
   // ***************************************************************
   ssa_op_type        op;
   logic              exec;
   logic [MA_W-1:0]   r_addr;
   logic [MA_W-1:0]   w_addr;
   logic [3:0]        imm;
   logic [3:0]        src_r;
   logic [3:0]        src_w;
   logic [4:0]        diff_r;
   logic [4:0]        diff_w;
   logic [3:0]        res_d;
   logic              carry_d;
   logic              acc_ld;
   logic              flag_upd;
   logic              wb_en;
   logic [MA_W-1:0]   wb_addr;
   logic [1:0]        pc_step;

   assign exec   = wr_en && (sel == ssa_sel_instr);
   assign op     = decode_op(pwdata[15:0]);
   assign r_addr = MA_W'(pwdata[6:0]);
   assign w_addr = MA_W'(pwdata[3:0]);
   assign imm    = pwdata[7:4];
   assign src_r  = mem_q[r_addr];
   assign src_w  = mem_q[w_addr];
   // bit 4 of the five-bit difference is the borrow out of bit 3
   assign diff_r = {1'b0, src_r} - {1'b0, acc_q} - {4'h0, carry_q};
   assign diff_w = {1'b0, src_w} - {1'b0, imm} - {4'h0, carry_q};

   always_comb begin
      res_d    = acc_q;
      carry_d  = carry_q;
      acc_ld   = 1'b0;
      flag_upd = 1'b0;
      wb_en    = 1'b0;
      wb_addr  = r_addr;
      pc_step  = 2'd1;
      case (op)
         ssa_op_subb_mem: begin
            res_d    = diff_r[3:0];
            carry_d  = diff_r[4];
            acc_ld   = 1'b1;
            flag_upd = 1'b1;
         end
         ssa_op_subb_imm: begin
            res_d    = diff_w[3:0];
            carry_d  = diff_w[4];
            acc_ld   = 1'b1;
            flag_upd = 1'b1;
         end
         ssa_op_subbw_mem: begin
            res_d    = diff_r[3:0];
            carry_d  = diff_r[4];
            acc_ld   = 1'b1;
            flag_upd = 1'b1;
            wb_en    = 1'b1;
         end
         ssa_op_subbw_imm: begin
            res_d    = diff_w[3:0];
            carry_d  = diff_w[4];
            acc_ld   = 1'b1;
            flag_upd = 1'b1;
            wb_en    = 1'b1;
            wb_addr  = w_addr;
         end
         ssa_op_shl_carry: begin
            res_d    = {src_r[2:0], 1'b0};
            carry_d  = src_r[3];
            acc_ld   = 1'b1;
            flag_upd = 1'b1;
            wb_en    = 1'b1;
         end
         ssa_op_shr_carry: begin
            res_d    = {1'b0, src_r[3:1]};
            carry_d  = src_r[0];
            acc_ld   = 1'b1;
            flag_upd = 1'b1;
            wb_en    = 1'b1;
         end
         ssa_op_skip_b0: begin
            pc_step  = src_r[0] ? 2'd2 : 2'd1;
         end
         default: begin
            res_d    = acc_q;
         end
      endcase
   end

   // ***************************************************************
   // accumulator
   // ***************************************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         acc_q <= `SSA_RST_NIBBLE;
      end else if (wr_en && sel == ssa_sel_acc) begin
         acc_q <= pwdata[3:0];
      end else if (exec && acc_ld) begin
         acc_q <= res_d;
      end
   end

   // ***************************************************************
   // flags
   // ***************************************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         carry_q <= `SSA_RST_FLAG;
         zero_q  <= `SSA_RST_FLAG;
      end else if (wr_en && sel == ssa_sel_flags) begin
         carry_q <= pwdata[`SSA_FLAGS_CARRY];
         zero_q  <= pwdata[`SSA_FLAGS_ZERO];
      end else if (exec && op == ssa_op_set_carry) begin
         carry_q <= 1'b1;
      end else if (exec && flag_upd) begin
         carry_q <= carry_d;
         zero_q  <= (res_d == 4'h0);
      end
   end

   // ***************************************************************
   // program counter
   // ***************************************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pc_q <= `SSA_RST_PC;
      end else if (wr_en && sel == ssa_sel_pc) begin
         pc_q <= pwdata[PC_W-1:0];
      end else if (exec) begin
         pc_q <= pc_q + PC_W'(pc_step);
      end
   end

   // ***************************************************************
   // parameter flags
   // ***************************************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wdt_slow_q <= `SSA_RST_FLAG;
      end else if (exec && op == ssa_op_set_param) begin
         wdt_slow_q <= pwdata[`SSA_PARAM_WDT_BIT];
      end
   end

   // ***************************************************************
   // data memory
   // ***************************************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i < MEM_DEPTH; i++) begin
            mem_q[i] <= `SSA_RST_NIBBLE;
         end
      end else if (wr_en && sel == ssa_sel_mem) begin
         mem_q[bus_idx] <= pwdata[3:0];
      end else if (exec && wb_en) begin
         mem_q[wb_addr] <= res_d;
      end
   end

   // ***************************************************************
   // read data, captured in the setup cycle
   // ***************************************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rdata_q <= 32'h0000_0000;
      end else if (psel && !penable && !pwrite) begin
         case (sel)
            ssa_sel_acc:   rdata_q <= {28'h0, acc_q};
            ssa_sel_flags: rdata_q <= {30'h0, zero_q, carry_q};
            ssa_sel_pc:    rdata_q <= 32'(pc_q);
            ssa_sel_param: rdata_q <= {28'h0, wdt_slow_q, 3'h0};
            ssa_sel_mem:   rdata_q <= {28'h0, mem_q[bus_idx]};
            default:       rdata_q <= 32'h0000_0000;
         endcase
      end
   end

   // ***************************************************************
   // watchdog clock divider
   // ***************************************************************
   logic [DIV_W-1:0] div_last;

   assign div_last = wdt_slow_q ? DIV_W'(WDT_SLOW_DIV - 1) : DIV_W'(WDT_FAST_DIV - 1);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_q  <= '0;
         tick_q <= 1'b0;
      end else if (div_q >= div_last) begin
         div_q  <= '0;
         tick_q <= 1'b1;
      end else begin
         div_q  <= div_q + DIV_W'(1);
         tick_q <= 1'b0;
      end
   end

   // ***************************************************************
   // outputs
   // ***************************************************************
   assign prdata            = rdata_q;
   assign result_nibble_reg = acc_q;
   assign carry_flag        = carry_q;
   assign zero_flag         = zero_q;
   assign program_counter   = pc_q;
   assign wdt_clk_slow      = wdt_slow_q;
   assign wdt_tick          = tick_q;

endmodule

// ### bench/ssa_alu_assertions.sv
`timescale 1ns/100ps
`include "ssa_params.svh"

module ssa_alu_assertions
   import ssa_pkg::*;
#(
   parameter int unsigned PC_W = 11
)(
   input wire logic            pclk,
   input wire logic            presetn,
   input wire logic            psel,
   input wire logic            penable,
   input wire logic            pwrite,
   input wire logic [11:0]     paddr,
   input wire logic [31:0]     pwdata,
   input wire logic [3:0]      pstrb,
   input wire logic [31:0]     prdata,
   input wire logic            pready,
   input wire logic            pslverr,
   input wire logic [3:0]      result_nibble_reg,
   input wire logic            carry_flag,
   input wire logic            zero_flag,
   input wire logic [PC_W-1:0] program_counter,
   input wire logic            wdt_clk_slow,
   input wire logic            wdt_tick
);
   logic [15:0] iw;
   logic        ex;
   logic        is_sub;
   logic        is_skip;
   logic        is_param;
   assign iw = pwdata[15:0];
   assign ex = psel && penable && pready && pwrite && pstrb[0] && paddr == 12'h000;
   assign is_sub = (iw & `SSA_MASK_R) == `SSA_CODE_SUBB_MEM || (iw & `SSA_MASK_R) == `SSA_CODE_SUBBW_MEM ||
                   (iw & `SSA_MASK_WI) == `SSA_CODE_SUBB_IMM || (iw & `SSA_MASK_WI) == `SSA_CODE_SUBBW_IMM;
   assign is_skip = (iw & `SSA_MASK_R) == `SSA_CODE_SKIP_B0;
   assign is_param = (iw & `SSA_MASK_PARAM) == `SSA_CODE_SET_PARAM;

   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);

   chk_set_carry: assert property (
      ex && iw == `SSA_CODE_SET_CARRY |=> carry_flag && $stable(zero_flag) && $stable(result_nibble_reg))
      else $error("set carry wrong");
   chk_shl_fill: assert property (
      ex && (iw & `SSA_MASK_R) == `SSA_CODE_SHL_CARRY |=> !result_nibble_reg[0])
      else $error("left shift fill wrong");
   chk_shr_fill: assert property (
      ex && (iw & `SSA_MASK_R) == `SSA_CODE_SHR_CARRY |=> !result_nibble_reg[3])
      else $error("right shift fill wrong");
   chk_sub_zero: assert property (
      ex && is_sub |=> zero_flag == (result_nibble_reg == 4'h0))
      else $error("zero flag wrong after subtract");
   chk_pc_step: assert property (
      ex && !is_skip |=> program_counter == PC_W'($past(program_counter) + 1'b1))
      else $error("pc step wrong");
   chk_skip_pc: assert property (
      ex && is_skip |=> (program_counter == PC_W'($past(program_counter) + 1'b1) ||
                        program_counter == PC_W'($past(program_counter) + 2'h2)) &&
                       $stable(carry_flag) && $stable(zero_flag))
      else $error("skip pc or flags wrong");
   chk_param_only: assert property (
      $changed(wdt_clk_slow) |-> $past(ex && is_param) && wdt_clk_slow == $past(pwdata[3]))
      else $error("watchdog clock select changed wrongly");
   chk_tick_gap: assert property (
      wdt_tick && wdt_clk_slow |=> !wdt_tick [*8])
      else $error("slow watchdog tick too soon");

   cover property (ex && is_sub);
   cover property (ex && is_skip);
   cover property (ex && is_param ##1 wdt_clk_slow);
   cover property (ex && (iw & `SSA_MASK_R) == `SSA_CODE_SHL_CARRY);
endmodule

bind ssa_alu ssa_alu_assertions #(.PC_W(PC_W)) ssa_alu_assertions_inst (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .result_nibble_reg(result_nibble_reg), .carry_flag(carry_flag),
   .zero_flag(zero_flag), .program_counter(program_counter), .wdt_clk_slow(wdt_clk_slow),
   .wdt_tick(wdt_tick)
);

// ### bench/ssa_alu_tb.sv
`timescale 1ns/100ps

module ssa_alu_tb
   import ssa_pkg::*;
;
   typedef struct packed {
      logic [6:0]  addr;
      logic [3:0]  m;
      logic [3:0]  a;
      logic        c;
      logic        z;
      logic [15:0] op;
      logic [3:0]  ea;
      logic        ec;
      logic        ez;
      logic [3:0]  em;
      logic [1:0]  dpc;
   } ssa_row_type;

   logic        pclk = 1'b0;
   logic        presetn = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [3:0]  pstrb = 4'h0;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic [3:0]  result_nibble_reg;
   logic        carry_flag;
   logic        zero_flag;
   logic [10:0] program_counter;
   logic        wdt_clk_slow;
   logic        wdt_tick;
   logic [31:0] rd;
   logic        er;
   int          err_total = 0;
   int          checks = 0;
   ssa_row_type r;
   logic [11:0] ma;

   // memory address, memory value, acc, carry, zero, instruction, then expected acc, carry, zero, memory, pc step
   ssa_row_type rows [13] = '{
      '{7'h45, 4'h5, 4'h3, 1'h1, 1'h0, 16'h1445, 4'h1, 1'h0, 1'h0, 4'h5, 2'h1},
      '{7'h7f, 4'h2, 4'h3, 1'h0, 1'h0, 16'h147f, 4'hf, 1'h1, 1'h0, 4'h2, 2'h1},
      '{7'h03, 4'h5, 4'h9, 1'h1, 1'h0, 16'h0e43, 4'h0, 1'h0, 1'h1, 4'h5, 2'h1},
      '{7'h10, 4'h3, 4'h5, 1'h1, 1'h0, 16'h1610, 4'hd, 1'h1, 1'h0, 4'hd, 2'h1},
      '{7'h0f, 4'h7, 4'h0, 1'h0, 1'h1, 16'h0f2f, 4'h5, 1'h0, 1'h0, 4'h5, 2'h1},
      '{7'h00, 4'h0, 4'h6, 1'h0, 1'h1, 16'h5020, 4'h6, 1'h1, 1'h1, 4'h0, 2'h1},
      '{7'h22, 4'h9, 4'h0, 1'h0, 1'h0, 16'h4c22, 4'h2, 1'h1, 1'h0, 4'h2, 2'h1},
      '{7'h23, 4'h8, 4'h5, 1'h0, 1'h0, 16'h4c23, 4'h0, 1'h1, 1'h1, 4'h0, 2'h1},
      '{7'h31, 4'h3, 4'h0, 1'h0, 1'h1, 16'h4d31, 4'h1, 1'h1, 1'h0, 4'h1, 2'h1},
      '{7'h32, 4'h1, 4'h0, 1'h0, 1'h0, 16'h4d32, 4'h0, 1'h1, 1'h1, 4'h0, 2'h1},
      '{7'h41, 4'h1, 4'h7, 1'h1, 1'h0, 16'h8841, 4'h7, 1'h1, 1'h0, 4'h1, 2'h2},
      '{7'h42, 4'he, 4'h7, 1'h0, 1'h1, 16'h8842, 4'h7, 1'h0, 1'h1, 4'he, 2'h1},
      '{7'h00, 4'h0, 4'h3, 1'h1, 1'h0, 16'h1688, 4'h3, 1'h1, 1'h0, 4'h0, 2'h1}
   };

   ssa_alu #(.WDT_SLOW_DIV(16), .WDT_FAST_DIV(4)) ssa_alu_inst (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .result_nibble_reg(result_nibble_reg), .carry_flag(carry_flag),
      .zero_flag(zero_flag), .program_counter(program_counter), .wdt_clk_slow(wdt_clk_slow),
      .wdt_tick(wdt_tick)
   );

   always #2 pclk = ~pclk;

   task automatic close_out();
      $display("checks=%0d err_total=%0d", checks, err_total);
      if (err_total == 0 && checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         err_total++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // one transfer: setup, access until pready, then one idle edge
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      pstrb <= s;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (pready !== 1'b1) begin
         err_total++;
         close_out();
      end
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask

   task automatic tick_gap(input int exp);
      int n;
      n = 0;
      while (wdt_tick !== 1'b1 && n < 100) begin
         @(posedge pclk);
         n++;
      end
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (wdt_tick !== 1'b1 && n < 100);
      chk(32'(n), 32'(exp));
   endtask

   initial begin
      #100000;
      err_total++;
      close_out();
   end

   initial begin
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      foreach (rows[i]) begin
         r = rows[i];
         ma = 12'h200 | {3'h0, r.addr, 2'h0};
         apb(1'b1, ma, {28'h0, r.m}, 4'hf);
         apb(1'b1, 12'h004, {28'h0, r.a}, 4'hf);
         apb(1'b1, 12'h008, {30'h0, r.z, r.c}, 4'hf);
         apb(1'b1, 12'h00c, 32'h7fe, 4'hf);
         apb(1'b1, 12'h000, {16'h0, r.op}, 4'hf);
         chk(32'(result_nibble_reg), 32'(r.ea));
         chk(32'(carry_flag), 32'(r.ec));
         chk(32'(zero_flag), 32'(r.ez));
         chk(32'(program_counter), 32'(11'(11'h7fe + r.dpc)));
         apb(1'b0, ma, 32'h0, 4'h0);
         chk(rd, 32'(r.em));
      end
      chk(32'(wdt_clk_slow), 32'h1);
      apb(1'b1, 12'h010, 32'h0, 4'hf);
      apb(1'b0, 12'h010, 32'h0, 4'h0);
      chk(rd, 32'h8);
      tick_gap(16);
      // carry set by one instruction feeds the very next subtract
      apb(1'b1, 12'h204, 32'h4, 4'hf);
      apb(1'b1, 12'h000, 32'h5020, 4'hf);
      apb(1'b1, 12'h000, 32'h0e01, 4'hf);
      chk(32'(result_nibble_reg), 32'h3);
      apb(1'b1, 12'h004, 32'h5, 4'hf);
      apb(1'b1, 12'h004, 32'ha, 4'h0);
      chk(32'(result_nibble_reg), 32'h5);
      apb(1'b0, 12'h100, 32'h0, 4'h0);
      chk({31'h0, er}, 32'h1);
      chk(rd, 32'h0);
      apb(1'b0, 12'h206, 32'h0, 4'h0);
      chk({31'h0, er}, 32'h1);
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      chk({12'h0, pready, pslverr, wdt_clk_slow, zero_flag, carry_flag, result_nibble_reg, program_counter},
          32'h0008_0000);
      presetn <= 1'b1;
      @(posedge pclk);
      apb(1'b0, 12'h314, 32'h0, 4'h0);
      chk(rd, 32'h0);
      tick_gap(4);
      close_out();
   end
endmodule
